// ---- logic/ttr_regs.sv ----
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Share bus register returns the 8-bit share bus voltage level.
// [RULE2] While this supply is share master the share bus register reads zero.
// [RULE3] Modulation register is an 8-bit read-only view of loop modulation.
// [RULE4] Modulation value spans none to full depth on modulating PWM edges.
// [RULE5] Line impedance reads local minus remote sense over secondary current.
// [RULE6] Trim bit 7 high gives negative gain correction, low gives positive.
// [RULE7] Trim bits 6 to 0 hold a readable, writable gain magnitude.
// [RULE8] Writes to read-only telemetry registers change no state at all.
module ttr_regs
    import ttr_pkg::*;
#(
    parameter int unsigned SW = SENSE_W
) (
    input  wire logic              CORE_CLK_I,
    input  wire logic              RST_N_I,
    input  wire logic              CLK_EN_I,
    input  wire logic [ADDR_W-1:0] REG_ADDR_I,
    input  wire logic              REG_WR_I,
    input  wire logic [DATA_W-1:0] REG_WDATA_I,
    input  wire logic              REG_RD_I,
    output logic      [DATA_W-1:0] REG_RDATA_O,
    output logic                   REG_RVALID_O,
    input  wire logic [7:0]        SHARE_BUS_LEVEL_I,
    input  wire logic              SHARE_MASTER_I,
    input  wire logic [7:0]        MOD_DEPTH_I,
    input  wire logic [SW-1:0]     LOCAL_VOLTAGE_SENSE_I,
    input  wire logic [SW-1:0]     REMOTE_VOLTAGE_SENSE_I,
    input  wire logic [SW-1:0]     SECONDARY_CURRENT_SENSE_I,
    input  wire logic              IMP_SAMPLE_I,
    output logic                   IMP_BUSY_O,
    output logic                   GAIN_NEG_O,
    output logic [TRIM_MAG_W-1:0]  GAIN_TRIM_O,
    output logic [7:0]             OCP_LIMIT_O
);
    typedef struct packed {
        logic [7:0] share;
        logic [7:0] mod;
        logic [7:0] imp;
        logic [7:0] trim;
        logic [7:0] ocp;
        logic [7:0] rdata;
        logic       rvalid;
    } ttr_st_t;

    ttr_st_t        st_r;
    ttr_st_t        st_nxt;
    logic [SW-1:0]  v_diff;
    logic           div_done;
    logic [7:0]     div_quot;

    function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return is_addr(a, OFS_SHARE_BUS) || is_addr(a, OFS_MOD_DEPTH)
            || is_addr(a, OFS_LINE_IMP) || is_addr(a, OFS_GAIN_TRIM)
            || is_addr(a, OFS_OCP_LIMIT);
    endfunction

    // =====================================================
    // Impedance divider
    // Remote above local clamps the drop to zero
    assign v_diff = (LOCAL_VOLTAGE_SENSE_I > REMOTE_VOLTAGE_SENSE_I)
                  ? LOCAL_VOLTAGE_SENSE_I - REMOTE_VOLTAGE_SENSE_I : '0; // [RULE5]

    ttr_imp_div #(
        .NW (SW)
    ) u_div (
        .clk_i      (CORE_CLK_I),
        .rst_n_i    (RST_N_I),
        .ce_i       (CLK_EN_I),
        .start_i    (IMP_SAMPLE_I),
        .dividend_i (v_diff),
        .divisor_i  (SECONDARY_CURRENT_SENSE_I),
        .busy_o     (IMP_BUSY_O),
        .done_o     (div_done),
        .quot_o     (div_quot)
    );

    // =====================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        // Telemetry capture
        st_nxt.share = SHARE_MASTER_I ? SHARE_MASTER_RD : SHARE_BUS_LEVEL_I; // [RULE1] [RULE2]
        st_nxt.mod   = MOD_DEPTH_I; // [RULE3] [RULE4]
        if (div_done) begin
            st_nxt.imp = div_quot; // [RULE5]
        end
        // Writes; read-only offsets fall through untouched
        if (REG_WR_I) begin
            if (is_addr(REG_ADDR_I, OFS_GAIN_TRIM)) begin
                st_nxt.trim = REG_WDATA_I; // [RULE6] [RULE7]
            end else if (is_addr(REG_ADDR_I, OFS_OCP_LIMIT)) begin
                st_nxt.ocp = REG_WDATA_I;
            end
        end // [RULE8]
        // Reads
        if (REG_RD_I) begin
            st_nxt.rvalid = 1'b1;
            case (REG_ADDR_I)
                OFS_SHARE_BUS: st_nxt.rdata = st_r.share; // [RULE1] [RULE2]
                OFS_MOD_DEPTH: st_nxt.rdata = st_r.mod; // [RULE3]
                OFS_LINE_IMP:  st_nxt.rdata = st_r.imp; // [RULE5]
                OFS_GAIN_TRIM: st_nxt.rdata = st_r.trim; // [RULE7]
                OFS_OCP_LIMIT: st_nxt.rdata = st_r.ocp;
                default:       st_nxt.rdata = RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_r        <= '0;
            st_r.share  <= RST_TELEMETRY;
            st_r.mod    <= RST_TELEMETRY;
            st_r.imp    <= RST_TELEMETRY;
            st_r.trim   <= RST_GAIN_TRIM;
            st_r.ocp    <= RST_OCP_LIMIT;
            st_r.rdata  <= RDATA_UNMAPPED;
        end else if (CLK_EN_I) begin
            st_r <= st_nxt;
        end
    end

    // =====================================================
    // Outputs
    assign REG_RDATA_O  = st_r.rdata;
    assign REG_RVALID_O = st_r.rvalid;
    assign GAIN_NEG_O   = st_r.trim[TRIM_POL_BIT]; // [RULE6]
    assign GAIN_TRIM_O  = st_r.trim[TRIM_MAG_MSB:0]; // [RULE7]
    assign OCP_LIMIT_O  = st_r.ocp;

    // =====================================================
    // Checks
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_share_level_read: assert property ( // [RULE1]
        CLK_EN_I && !SHARE_MASTER_I
        ##1 CLK_EN_I && REG_RD_I && REG_ADDR_I == OFS_SHARE_BUS
        |=> REG_RVALID_O && REG_RDATA_O == $past(SHARE_BUS_LEVEL_I, 2))
        else $error("Share bus read does not match bus level");

    a_share_master_zero: assert property ( // [RULE2]
        CLK_EN_I && SHARE_MASTER_I
        ##1 CLK_EN_I && REG_RD_I && REG_ADDR_I == OFS_SHARE_BUS
        |=> REG_RDATA_O == SHARE_MASTER_RD)
        else $error("Share bus read nonzero while master");

    a_mod_depth_read: assert property ( // [RULE3]
        CLK_EN_I ##1 CLK_EN_I && REG_RD_I && REG_ADDR_I == OFS_MOD_DEPTH
        |=> REG_RDATA_O == $past(MOD_DEPTH_I, 2))
        else $error("Modulation read does not match loop value");

    a_mod_full_scale: assert property ( // [RULE4]
        CLK_EN_I && MOD_DEPTH_I == 8'hFF
        ##1 CLK_EN_I && REG_RD_I && REG_ADDR_I == OFS_MOD_DEPTH
        |=> REG_RDATA_O == 8'hFF)
        else $error("Full modulation depth not reported");

    a_imp_capture: assert property ( // [RULE5]
        CLK_EN_I && div_done
        ##1 CLK_EN_I && REG_RD_I && REG_ADDR_I == OFS_LINE_IMP
        |=> REG_RDATA_O == $past(div_quot, 2))
        else $error("Impedance read misses divider result");

    a_trim_polarity: assert property ( // [RULE6]
        CLK_EN_I && REG_WR_I && REG_ADDR_I == OFS_GAIN_TRIM
        |=> GAIN_NEG_O == $past(REG_WDATA_I[TRIM_POL_BIT]))
        else $error("Trim polarity not applied");

    a_trim_readback: assert property ( // [RULE7]
        CLK_EN_I && REG_WR_I && REG_ADDR_I == OFS_GAIN_TRIM
        ##1 CLK_EN_I && !REG_WR_I && REG_RD_I && REG_ADDR_I == OFS_GAIN_TRIM
        |=> REG_RDATA_O == $past(REG_WDATA_I, 2)
            && GAIN_TRIM_O == $past(REG_WDATA_I[TRIM_MAG_MSB:0], 2))
        else $error("Trim magnitude readback mismatch");

    a_ro_write_ignored: assert property ( // [RULE8]
        CLK_EN_I && REG_WR_I && (REG_ADDR_I == OFS_SHARE_BUS
            || REG_ADDR_I == OFS_MOD_DEPTH || REG_ADDR_I == OFS_LINE_IMP)
        |=> $stable({GAIN_NEG_O, GAIN_TRIM_O, OCP_LIMIT_O}))
        else $error("Write to read-only offset changed state");

    a_freeze_hold: assert property (
        !CLK_EN_I |=> $stable({REG_RDATA_O, REG_RVALID_O, GAIN_NEG_O, OCP_LIMIT_O}))
        else $error("State moved while clock enable low");

    // =====================================================
    // Read port, write, divider start and capture checks
    a_rvalid_pulse: assert property (
        CLK_EN_I |=> REG_RVALID_O == $past(REG_RD_I))
        else $error("Read answer pulse does not follow read strobe");

    a_rdata_hold: assert property (
        CLK_EN_I && !REG_RD_I |=> $stable(REG_RDATA_O))
        else $error("Read data moved without a read");

    a_unmapped_read: assert property (
        CLK_EN_I && REG_RD_I && !is_mapped(REG_ADDR_I) |=> REG_RDATA_O == RDATA_UNMAPPED)
        else $error("Unmapped read returned nonzero data");

    a_share_master_capture: assert property ( // [RULE2]
        CLK_EN_I && SHARE_MASTER_I |=> st_r.share == SHARE_MASTER_RD)
        else $error("Share level captured while master");

    a_mod_ro_write: assert property ( // [RULE8]
        CLK_EN_I && REG_WR_I && REG_ADDR_I == OFS_MOD_DEPTH
        |=> st_r.mod == $past(MOD_DEPTH_I))
        else $error("Write disturbed modulation capture");

    a_imp_hold: assert property ( // [RULE8]
        CLK_EN_I && !div_done |=> $stable(st_r.imp))
        else $error("Impedance changed without a divider result");

    a_ocp_write: assert property (
        CLK_EN_I && REG_WR_I && REG_ADDR_I == OFS_OCP_LIMIT
        |=> OCP_LIMIT_O == $past(REG_WDATA_I))
        else $error("Limit write not applied");

    a_rw_old_value: assert property (
        CLK_EN_I && REG_RD_I && REG_WR_I && REG_ADDR_I == OFS_OCP_LIMIT
        |=> REG_RDATA_O == $past(OCP_LIMIT_O))
        else $error("Read in write cycle did not return old value");

    a_imp_start: assert property ( // [RULE5]
        CLK_EN_I && IMP_SAMPLE_I && !IMP_BUSY_O |=> IMP_BUSY_O)
        else $error("Impedance division did not start");
endmodule

// ---- common/ttr_pkg.sv ----
package ttr_pkg;
    // =====================================================
    // Register map
    localparam int unsigned ADDR_W          = 8;
    localparam int unsigned DATA_W          = 8;
    localparam logic [7:0]  OFS_SHARE_BUS   = 8'h1D;
    localparam logic [7:0]  OFS_MOD_DEPTH   = 8'h1E;
    localparam logic [7:0]  OFS_LINE_IMP    = 8'h1F;
    localparam logic [7:0]  OFS_GAIN_TRIM   = 8'h21;
    localparam logic [7:0]  OFS_OCP_LIMIT   = 8'h22;
    // =====================================================
    // Field layout
    localparam int unsigned TRIM_POL_BIT    = 7;
    localparam int unsigned TRIM_MAG_MSB    = 6;
    localparam int unsigned TRIM_MAG_W      = 7;
    // =====================================================
    // Reset and fixed values
    localparam logic [7:0]  RST_GAIN_TRIM   = 8'h00;
    localparam logic [7:0]  RST_OCP_LIMIT   = 8'h00;
    localparam logic [7:0]  RST_TELEMETRY   = 8'h00;
    localparam logic [7:0]  RDATA_UNMAPPED  = 8'h00;
    localparam logic [7:0]  SHARE_MASTER_RD = 8'h00;
    localparam logic [7:0]  IMP_SATURATED   = 8'hFF;
    // =====================================================
    // Sense widths and divider timing
    localparam int unsigned SENSE_W         = 12;
    localparam int unsigned DIV_CYCLES      = SENSE_W + 1;
endpackage

// ---- logic/ttr_imp_div.sv ----
`timescale 1ns/1ps
// Restoring divider for the line impedance reading
module ttr_imp_div
    import ttr_pkg::*;
#(
    parameter int unsigned NW = SENSE_W
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          ce_i,
    input  wire logic          start_i,
    input  wire logic [NW-1:0] dividend_i,
    input  wire logic [NW-1:0] divisor_i,
    output logic               busy_o,
    output logic               done_o,
    output logic [7:0]         quot_o
);
    localparam int unsigned CW = $clog2(NW + 1);

    typedef struct packed {
        logic          busy;
        logic          done;
        logic [CW-1:0] cnt;
        logic [NW:0]   rem;
        logic [NW-1:0] q;
        logic [NW-1:0] div;
        logic [7:0]    res;
    } ttr_div_st_t;

    ttr_div_st_t st_r;
    ttr_div_st_t st_nxt;

    // =====================================================
    // Next state
    always_comb begin
        logic [NW:0] rem_sh;
        rem_sh = '0;
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (!st_r.busy && start_i) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt  = CW'(NW);
            st_nxt.rem  = '0;
            st_nxt.q    = dividend_i;
            st_nxt.div  = divisor_i;
        end else if (st_r.busy) begin
            rem_sh = {st_r.rem[NW-1:0], st_r.q[NW-1]};
            st_nxt.q = {st_r.q[NW-2:0], 1'b0};
            if (rem_sh >= {1'b0, st_r.div}) begin
                st_nxt.rem  = rem_sh - {1'b0, st_r.div};
                st_nxt.q[0] = 1'b1;
            end else begin
                st_nxt.rem = rem_sh;
            end
            st_nxt.cnt = st_r.cnt - 1'b1;
            if (st_r.cnt == CW'(1)) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
                // Quotient above 8 bits, or zero current, saturates
                if (st_nxt.q > NW'(IMP_SATURATED)) begin // [RULE5]
                    st_nxt.res = IMP_SATURATED;
                end else begin
                    st_nxt.res = st_nxt.q[7:0]; // [RULE5]
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign busy_o = st_r.busy;
    assign done_o = st_r.done;
    assign quot_o = st_r.res;

    // =====================================================
    // Checks
    a_div_zero_sat: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE5]
        done_o && st_r.div == '0 |-> quot_o == IMP_SATURATED)
        else $error("Zero current did not saturate impedance");
    a_div_done_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && ce_i |=> !done_o)
        else $error("Divider done held longer than one cycle");
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
    import ttr_pkg::*;
    // ==========================================
    // Stimulus and observed signals
    logic                  clk;
    logic                  rst_n;
    logic                  en;
    logic                  wr;
    logic                  rd;
    logic                  master;
    logic                  samp;
    logic                  rvalid;
    logic                  busy;
    logic                  gneg;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
    logic [DATA_W-1:0]     rdata;
    logic [7:0]            share;
    logic [7:0]            depth;
    logic [7:0]            ocp;
    logic [SENSE_W-1:0]    loc;
    logic [SENSE_W-1:0]    rem;
    logic [SENSE_W-1:0]    cur;
    logic [TRIM_MAG_W-1:0] gmag;
    int                    miscompares = 0;
    int                    compares = 0;
    always #5 clk = ~clk;
    ttr_regs #(.SW(SENSE_W)) DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(en),
        .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .SHARE_BUS_LEVEL_I(share),
        .SHARE_MASTER_I(master), .MOD_DEPTH_I(depth), .LOCAL_VOLTAGE_SENSE_I(loc),
        .REMOTE_VOLTAGE_SENSE_I(rem), .SECONDARY_CURRENT_SENSE_I(cur), .IMP_SAMPLE_I(samp),
        .IMP_BUSY_O(busy), .GAIN_NEG_O(gneg), .GAIN_TRIM_O(gmag), .OCP_LIMIT_O(ocp));
    // ==========================================
    // Shared tasks
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic give_up(input string msg);
        check(8'h00, 8'h01, msg);
        report_and_stop();
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        int i;
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        for (i = 0; i < 4 && rvalid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (rvalid !== 1'b1) give_up("read answer missing");
        d = rdata;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_telemetry();
        logic [7:0] d;
        logic [7:0] tbl [3] = '{8'h00, 8'h80, 8'hFF};
        @(posedge clk);
        share <= 8'h5A;
        repeat (2) @(posedge clk);
        rd_reg(OFS_SHARE_BUS, d);
        check(d, 8'h5A, "share level");
        @(posedge clk);
        master <= 1'b1;
        repeat (2) @(posedge clk);
        rd_reg(OFS_SHARE_BUS, d);
        check(d, SHARE_MASTER_RD, "share as master");
        foreach (tbl[k]) begin
            @(posedge clk);
            master <= 1'b0;
            depth  <= tbl[k];
            repeat (2) @(posedge clk);
            rd_reg(OFS_MOD_DEPTH, d);
            check(d, tbl[k], "modulation depth");
        end
        $display("test telemetry done");
    endtask
    task automatic t_imp(input logic [11:0] l, input logic [11:0] r, input logic [11:0] c,
                         input logic [7:0] e);
        logic [7:0] d;
        int         n;
        @(posedge clk);
        loc <= l;
        rem <= r;
        cur <= c;
        samp <= 1'b1;
        @(posedge clk);
        samp <= 1'b0;
        #1;
        for (n = 0; n < 3 && busy !== 1'b1; n++) @(posedge clk) #1;
        for (n = 0; n < 40 && busy === 1'b1; n++) @(posedge clk) #1;
        if (busy !== 1'b0) give_up("divider hang");
        check(8'(n), 8'(SENSE_W), "busy length");
        rd_reg(OFS_LINE_IMP, d);
        check(d, e, "line impedance");
    endtask
    task automatic t_trim();
        logic [7:0] d;
        wr_reg(OFS_GAIN_TRIM, 8'h85);
        check({7'h00, gneg}, 8'h01, "negative polarity");
        check({1'b0, gmag}, 8'h05, "trim magnitude");
        // Write then read back to back
        @(posedge clk);
        addr  <= OFS_GAIN_TRIM;
        wdata <= 8'h7F;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b1;
        @(posedge clk);
        rd    <= 1'b0;
        #1;
        check({7'h00, gneg}, 8'h00, "positive polarity");
        check({7'h00, rvalid}, 8'h01, "trim read answer");
        check(rdata, 8'h7F, "trim read back");
        // Read and write in one cycle returns the old value
        @(posedge clk);
        addr  <= OFS_OCP_LIMIT;
        wdata <= 8'hA6;
        wr    <= 1'b1;
        rd    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b0;
        #1;
        check(rdata, RST_OCP_LIMIT, "limit read in write cycle");
        check(ocp, 8'hA6, "limit applied");
        rd_reg(OFS_OCP_LIMIT, d);
        check(d, 8'hA6, "limit read back");
        $display("test trim done");
    endtask
    task automatic t_readonly();
        logic [7:0] d;
        @(posedge clk);
        depth <= 8'h44;
        wr_reg(OFS_MOD_DEPTH, 8'h33);
        wr_reg(OFS_SHARE_BUS, 8'h33);
        wr_reg(OFS_LINE_IMP, 8'h33);
        rd_reg(OFS_MOD_DEPTH, d);
        check(d, 8'h44, "depth after write");
        rd_reg(OFS_LINE_IMP, d);
        check(d, 8'hFF, "impedance after write");
        check({gneg, gmag}, 8'h7F, "trim after writes");
        check(ocp, 8'hA6, "limit after writes");
        rd_reg(8'h40, d);
        check(d, RDATA_UNMAPPED, "unmapped read");
        @(posedge clk);
        en <= 1'b0;
        wr_reg(OFS_OCP_LIMIT, 8'h11);
        @(posedge clk);
        en <= 1'b1;
        #1;
        check(ocp, 8'hA6, "write while frozen");
        $display("test read only done");
    endtask
    task automatic t_reset();
        logic [7:0] d;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({gneg, gmag}, RST_GAIN_TRIM, "trim after reset");
        check(ocp, RST_OCP_LIMIT, "limit after reset");
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check({6'h00, busy, rvalid}, 8'h00, "flags after reset");
        rd_reg(OFS_LINE_IMP, d);
        check(d, RST_TELEMETRY, "impedance after reset");
        $display("test reset done");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {clk, rst_n, wr, rd, master, samp, addr, wdata, share, depth} = '0;
        {loc, rem, cur} = '0;
        en = 1'b1;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check({gneg, gmag}, RST_GAIN_TRIM, "trim reset");
        check(ocp, RST_OCP_LIMIT, "limit reset");
        check({6'h00, busy, rvalid}, 8'h00, "flags reset");
        t_telemetry();
        t_imp(12'h3E8, 12'h190, 12'h007, 8'h55);
        t_imp(12'h190, 12'h3E8, 12'h007, 8'h00);
        t_imp(12'hBB8, 12'h000, 12'h002, IMP_SATURATED);
        t_imp(12'h384, 12'h064, 12'h000, IMP_SATURATED);
        $display("test impedance done");
        t_trim();
        t_readonly();
        t_reset();
        report_and_stop();
    end
endmodule
